// ===== verilog/ssa_pkg.sv
// Purpose: Shared constants and types for the serial slave port and its bus master
// Assumes: 50 MHz system clock, open-drain data line with a pull-up
// Notes:   Byte values include the direction bit in bit 0
package ssa_pkg;
   localparam logic [2:0] ADDR_FIXED     = 3'h2;
   localparam logic [3:0] ADDR_SEL_RESET = 4'hf;
   localparam logic [7:0] GLOBAL_WR      = 8'h60;
   localparam logic [7:0] GLOBAL_RD      = 8'h61;
   localparam logic [7:0] PTR_RESET      = 8'h00;
   localparam logic [7:0] PTR_LAST       = 8'h26;
   localparam logic [7:0] PTR_STEP       = 8'h01;
   localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
   localparam logic [3:0] BIT_ONE        = 4'h1;
   localparam logic [3:0] BIT_ZERO       = 4'h0;
   localparam int         CLK_PERIOD_NS  = 20;
   localparam int         LINK_PERIOD_NS = 160;
   localparam int         SCL_QTR_CYC    = (LINK_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

   typedef enum logic [2:0]
   {
      DEV_IDLE   = 3'h0,
      DEV_RX     = 3'h1,
      DEV_RXACK  = 3'h3,
      DEV_TX     = 3'h2,
      DEV_TXACK  = 3'h6,
      DEV_IGNORE = 3'h4
   } ssa_dev_state_e;

   typedef enum logic [1:0]
   {
      HST_IDLE  = 2'h0,
      HST_START = 2'h1,
      HST_BITS  = 2'h3,
      HST_STOP  = 2'h2
   } ssa_host_state_e;
endpackage : ssa_pkg

// ===== verilog/ssa_link_if.sv
// Purpose: Serial clock and open-drain data wiring between master and slave
// Assumes: Pull-up on the data line; clock driven push-pull by the master
// Notes:   Bus level is resolved here from both output enables
`timescale 1ns/100ps
interface ssa_link_if;
   logic scl;
   logic sda_out_b;
   logic sda_out_b_oe_n;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic sda_in_a;

   // Wired-AND of both open-drain drivers
   assign sda_in_a = (sda_out_b_oe_n | sda_out_b) & (host_sda_oe_n | host_sda_o);

   modport dev
   (
      input  scl,
      input  sda_in_a,
      output sda_out_b,
      output sda_out_b_oe_n
   );

   modport host
   (
      output scl,
      output host_sda_o,
      output host_sda_oe_n,
      input  sda_in_a
   );
endinterface : ssa_link_if

// ===== verilog/ssa_host.sv
// Purpose: Bus master that frames bytes with START, STOP and acknowledge
// Assumes: One command byte at a time; clock stays low between bytes
// Notes:   Clock period is four phases of QTR system cycles each
`timescale 1ns/100ps
module ssa_host #(
   parameter int QTR = ssa_pkg::SCL_QTR_CYC
) (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   ssa_link_if.host        link,
   input  wire logic       cmd_valid_i,
   output logic            cmd_ready_o,
   input  wire logic       cmd_start_i,
   input  wire logic       cmd_stop_i,
   input  wire logic       cmd_read_i,
   input  wire logic       cmd_ack_i,
   input  wire logic [7:0] cmd_wdata_i,
   output logic            rsp_valid_o,
   output logic [7:0]      rsp_rdata_o,
   output logic            rsp_ack_o
);
   localparam logic [7:0] QTR_M1 = 8'(QTR - 1);

   ssa_pkg::ssa_host_state_e st;
   logic [7:0] div;
   logic [1:0] q;
   logic [3:0] bitn;
   logic [8:0] sh;
   logic [8:0] rx;
   logic       scl;
   logic       sda_low;
   logic       stop_f;
   logic       sda_m;
   logic       sda_s;

   wire        tick   = (div == QTR_M1);
   wire        accept = cmd_valid_i & (st == ssa_pkg::HST_IDLE);
   wire [8:0]  rx_all = {rx[7:0], sda_s};
   wire        last   = (bitn == ssa_pkg::BITS_PER_BYTE);

   assign cmd_ready_o        = (st == ssa_pkg::HST_IDLE);
   assign link.scl           = scl;
   assign link.host_sda_o    = 1'b0;
   assign link.host_sda_oe_n = ~sda_low;

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         st          <= ssa_pkg::HST_IDLE;
         div         <= 8'h00;
         q           <= 2'h0;
         bitn        <= ssa_pkg::BIT_ZERO;
         sh          <= 9'h1ff;
         rx          <= 9'h000;
         scl         <= 1'b1;
         sda_low     <= 1'b0;
         stop_f      <= 1'b0;
         sda_m       <= 1'b1;
         sda_s       <= 1'b1;
         rsp_valid_o <= 1'b0;
         rsp_rdata_o <= 8'h00;
         rsp_ack_o   <= 1'b0;
      end
      else
      begin
         sda_m       <= link.sda_in_a;
         sda_s       <= sda_m;
         rsp_valid_o <= 1'b0;
         div         <= (tick | accept) ? 8'h00 : div + 8'h01;
         if (accept)
         begin
            // Read bytes release the line for eight bits, then ack
            st     <= cmd_start_i ? ssa_pkg::HST_START : ssa_pkg::HST_BITS;
            q      <= 2'h0;
            bitn   <= ssa_pkg::BIT_ZERO;
            sh     <= cmd_read_i ? {8'hff, ~cmd_ack_i} : {cmd_wdata_i, 1'b1};
            stop_f <= cmd_stop_i;
         end
         else if (tick && st != ssa_pkg::HST_IDLE)
         begin
            q <= q + 2'h1;
            case (st)
               ssa_pkg::HST_START:
               begin
                  // Release, raise clock, drop data with clock high
                  case (q)
                     2'h0:    sda_low <= 1'b0;
                     2'h1:    scl <= 1'b1;
                     2'h2:    sda_low <= 1'b1;
                     default:
                     begin
                        scl <= 1'b0;
                        st  <= ssa_pkg::HST_BITS;
                     end
                  endcase
               end
               ssa_pkg::HST_BITS:
               begin
                  // Data changes only while clock is low
                  case (q)
                     2'h0:    sda_low <= ~sh[8];
                     2'h1:    scl <= 1'b1;
                     2'h2:    scl <= 1'b1;
                     default:
                     begin
                        scl  <= 1'b0;
                        rx   <= rx_all;
                        sh   <= {sh[7:0], 1'b1};
                        bitn <= bitn + ssa_pkg::BIT_ONE;
                        if (last)
                        begin
                           rsp_valid_o <= 1'b1;
                           rsp_rdata_o <= rx_all[8:1];
                           rsp_ack_o   <= ~rx_all[0];
                           st          <= stop_f ? ssa_pkg::HST_STOP : ssa_pkg::HST_IDLE;
                        end
                     end
                  endcase
               end
               ssa_pkg::HST_STOP:
               begin
                  // Rising data with clock high frees the bus
                  case (q)
                     2'h0:    sda_low <= 1'b1;
                     2'h1:    scl <= 1'b1;
                     2'h2:    sda_low <= 1'b0;
                     default: st <= ssa_pkg::HST_IDLE;
                  endcase
               end
               default: st <= ssa_pkg::HST_IDLE;
            endcase
         end
      end
   end
endmodule : ssa_host

// ===== verilog/ssa_slave.sv
// Purpose: Serial slave port with pointer, global write and alert response
// Assumes: Master owns the clock; register file sits on the user side
// Notes:   All bus inputs are oversampled by the system clock
// Function
// - Address is 010 plus four selector bits
// - Selector captured at reset release or power-up
// - Captured selector readable as latched address register
// - Watch for START plus own address, acknowledge
// - Eighth bit low writes, high reads
// - Master frames START, address, pointer, data, STOP
// - Idle high; START/STOP are data edges, clock high
// - One bit per clock, data stable while high
// - Receiver pulls data low during ninth clock
// - Device acknowledges writes, master acknowledges reads
// - Data output only pulls low or releases
// - Master starts transfers and makes all clocks
// - Global write address 0x60 accepted and acknowledged
// - Global read 0x61 answered only with interrupt
// - Alert response shifts own address, MSB first
// - Lose arbitration on mismatch, release until end
// - Alert response leaves interrupt untouched
// - First write byte is pointer, then data
// - STOP after pointer only keeps pointer
// - Pointer advances per byte, sticks at 0x26
// - Reads use stored pointer with same advance
`timescale 1ns/100ps
module ssa_slave (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   ssa_link_if.dev         link,
   input  wire logic [3:0] addr_sel_i,
   input  wire logic       power_up_i,
   input  wire logic       int_active_i,
   input  wire logic [7:0] reg_rdata_i,
   output logic [7:0]      reg_addr_o,
   output logic [7:0]      reg_wdata_o,
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   output logic [3:0]      latched_address_register_o
);
   ssa_pkg::ssa_dev_state_e st;
   logic       scl_m;
   logic       scl_s;
   logic       scl_d;
   logic       sda_m;
   logic       sda_s;
   logic       sda_d;
   logic [3:0] sel_m;
   logic [3:0] sel_s;
   logic       cap_pend;
   logic [3:0] addr_lat;
   logic [3:0] cnt;
   logic [7:0] sh;
   logic [7:0] ptr;
   logic       addr_phase;
   logic       ptr_phase;
   logic       rd_mode;
   logic       alert;
   logic       ack_ok;
   logic       m_ack;
   logic       txbit;
   logic       drive_low;

   // Edges come from synchronised samples only
   wire       scl_rise  = scl_s & ~scl_d;
   wire       scl_fall  = ~scl_s & scl_d;
   wire       start_det = scl_s & scl_d & sda_d & ~sda_s;
   wire       stop_det  = scl_s & scl_d & ~sda_d & sda_s;

   wire [6:0] own_addr  = {ssa_pkg::ADDR_FIXED, addr_lat};
   wire [7:0] rx_byte   = {sh[6:0], sda_s};
   wire       own_hit   = (rx_byte[7:1] == own_addr);
   wire       glob_wr   = (rx_byte == ssa_pkg::GLOBAL_WR);
   // Interrupt is only observed here, never cleared
   wire       glob_rd   = (rx_byte == ssa_pkg::GLOBAL_RD) & int_active_i;
   wire       addr_ok   = own_hit | glob_wr | glob_rd;
   wire       byte_end  = (cnt == ssa_pkg::BITS_PER_BYTE);
   wire       last_rx   = (cnt == ssa_pkg::BITS_PER_BYTE - ssa_pkg::BIT_ONE);
   // Pointer saturates instead of wrapping
   wire [7:0] ptr_next  = (ptr == ssa_pkg::PTR_LAST) ? ptr : ptr + ssa_pkg::PTR_STEP;
   // Alert answer is own address then a released eighth bit
   wire [7:0] tx_word   = alert ? {own_addr, 1'b1} : reg_rdata_i;
   wire       load_tx   = scl_fall & (((st == ssa_pkg::DEV_RXACK) & rd_mode) |
                                      ((st == ssa_pkg::DEV_TXACK) & m_ack & ~alert));
   wire       arb_lost  = scl_rise & alert & (st == ssa_pkg::DEV_TX) & (sda_s != txbit);

   assign latched_address_register_o = addr_lat;
   assign link.sda_out_b             = 1'b0;
   assign link.sda_out_b_oe_n        = ~drive_low;

   // Pin synchronisers run through reset so valid levels exist at release
   always_ff @(posedge clk_i)
   begin
      scl_m <= link.scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= link.sda_in_a;
      sda_s <= sda_m;
      sda_d <= sda_s;
      sel_m <= addr_sel_i;
      sel_s <= sel_m;
      if (!rst_n_i)
      begin
         cap_pend <= 1'b1;
         addr_lat <= ssa_pkg::ADDR_SEL_RESET;
      end
      else if (cap_pend)
      begin
         addr_lat <= sel_s;
         // A power-up in the same cycle wins and captures once more
         cap_pend <= power_up_i;
      end
      else if (power_up_i)
      begin
         cap_pend <= 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         st          <= ssa_pkg::DEV_IDLE;
         cnt         <= ssa_pkg::BIT_ZERO;
         sh          <= 8'h00;
         ptr         <= ssa_pkg::PTR_RESET;
         addr_phase  <= 1'b0;
         ptr_phase   <= 1'b0;
         rd_mode     <= 1'b0;
         alert       <= 1'b0;
         ack_ok      <= 1'b0;
         m_ack       <= 1'b0;
         txbit       <= 1'b1;
         drive_low   <= 1'b0;
         reg_addr_o  <= 8'h00;
         reg_wdata_o <= 8'h00;
         reg_wr_o    <= 1'b0;
         reg_rd_o    <= 1'b0;
      end
      else
      begin
         reg_wr_o <= 1'b0;
         reg_rd_o <= 1'b0;
         if (start_det)
         begin
            // Any START, repeated or not, re-enters addressing; pointer kept
            st         <= ssa_pkg::DEV_RX;
            cnt        <= ssa_pkg::BIT_ZERO;
            addr_phase <= 1'b1;
            alert      <= 1'b0;
            drive_low  <= 1'b0;
         end
         else if (stop_det)
         begin
            // Nothing pending is written, so pointer-only frames end here
            st        <= ssa_pkg::DEV_IDLE;
            drive_low <= 1'b0;
         end
         else if (load_tx)
         begin
            // First bit goes out on the falling clock edge
            st        <= ssa_pkg::DEV_TX;
            cnt       <= ssa_pkg::BIT_ONE;
            sh        <= {tx_word[6:0], 1'b0};
            txbit     <= tx_word[7];
            drive_low <= ~tx_word[7];
         end
         else if (arb_lost)
         begin
            st        <= ssa_pkg::DEV_IGNORE;
            drive_low <= 1'b0;
         end
         else
         begin
            case (st)
               ssa_pkg::DEV_RX:
               begin
                  if (scl_rise)
                  begin
                     sh  <= rx_byte;
                     cnt <= cnt + ssa_pkg::BIT_ONE;
                     if (last_rx && addr_phase)
                     begin
                        ack_ok     <= addr_ok;
                        rd_mode    <= rx_byte[0];
                        alert      <= glob_rd & rx_byte[0];
                        ptr_phase  <= ~rx_byte[0];
                        addr_phase <= 1'b0;
                        if (addr_ok && rx_byte[0] && !glob_rd)
                        begin
                           reg_rd_o   <= 1'b1;
                           reg_addr_o <= ptr;
                        end
                     end
                     else if (last_rx)
                     begin
                        ack_ok    <= 1'b1;
                        ptr_phase <= 1'b0;
                        if (ptr_phase)
                           ptr <= rx_byte;
                        else
                        begin
                           reg_wr_o    <= 1'b1;
                           reg_addr_o  <= ptr;
                           reg_wdata_o <= rx_byte;
                           ptr         <= ptr_next;
                        end
                     end
                  end
                  else if (scl_fall && byte_end)
                  begin
                     // Acknowledge held low for the whole ninth clock
                     st        <= ack_ok ? ssa_pkg::DEV_RXACK : ssa_pkg::DEV_IGNORE;
                     drive_low <= ack_ok;
                  end
               end
               ssa_pkg::DEV_RXACK:
                  if (scl_fall)
                  begin
                     st        <= ssa_pkg::DEV_RX;
                     cnt       <= ssa_pkg::BIT_ZERO;
                     drive_low <= 1'b0;
                  end
               ssa_pkg::DEV_TX:
               begin
                  if (scl_fall && byte_end)
                  begin
                     // Release for the master's acknowledge
                     st        <= ssa_pkg::DEV_TXACK;
                     drive_low <= 1'b0;
                     if (!alert)
                        ptr <= ptr_next;
                  end
                  else if (scl_fall)
                  begin
                     txbit     <= sh[7];
                     drive_low <= ~sh[7];
                     sh        <= {sh[6:0], 1'b0};
                     cnt       <= cnt + ssa_pkg::BIT_ONE;
                  end
               end
               ssa_pkg::DEV_TXACK:
               begin
                  if (scl_rise)
                  begin
                     m_ack <= ~sda_s;
                     if (!sda_s && !alert)
                     begin
                        reg_rd_o   <= 1'b1;
                        reg_addr_o <= ptr;
                     end
                  end
                  else if (scl_fall)
                  begin
                     // Not acknowledged, or alert answered: wait for STOP or START
                     st <= ssa_pkg::DEV_IGNORE;
                  end
               end
               ssa_pkg::DEV_IGNORE: drive_low <= 1'b0;
               default:
               begin
                  st        <= ssa_pkg::DEV_IDLE;
                  drive_low <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule : ssa_slave

// ===== test/ssa_chk.sv
// Purpose: Concurrent checks on the serial link between master and slave
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Takes the interface signals as plain inputs
`timescale 1ns/100ps
module ssa_chk #(
   parameter int QTR = 2
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic scl,
   input wire logic sda_out_b,
   input wire logic sda_out_b_oe_n,
   input wire logic host_sda_o,
   input wire logic host_sda_oe_n,
   input wire logic sda_in_a
);
   logic       scl_q;
   logic       sda_q;
   logic       bus_free;
   logic [7:0] hi_cnt;
   wire        stop_w        = scl & scl_q & sda_in_a & ~sda_q;
   wire        start_w       = scl & scl_q & ~sda_in_a & sda_q;
   wire        next_bus_free = stop_w | (bus_free & ~start_w);
   wire  [7:0] next_hi_cnt   = !scl ? 8'h00 : ((hi_cnt == 8'hff) ? hi_cnt : hi_cnt + 8'h01);

   always_ff @(posedge clk_i)
   begin
      scl_q    <= scl;
      sda_q    <= sda_in_a;
      bus_free <= !rst_n_i | next_bus_free;
      hi_cnt   <= rst_n_i ? next_hi_cnt : 8'h00;
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_drive_low_only: assert property (!sda_out_b_oe_n |-> !sda_out_b)
      else $error("slave drove the data line high");
   a_host_low_only: assert property (!host_sda_oe_n |-> !host_sda_o)
      else $error("master drove the data line high");
   a_drive_clock_low: assert property ($fell(sda_out_b_oe_n) |-> !$past(scl))
      else $error("slave began driving while the clock was high");
   a_hold_while_high: assert property ((scl && !sda_out_b_oe_n) |=> (!scl || !sda_out_b_oe_n))
      else $error("slave released the data line while the clock was high");
   a_stable_high: assert property ((scl && $past(scl) && !$stable(sda_in_a)) |-> !$stable(host_sda_oe_n))
      else $error("data line changed by the slave while the clock was high");
   a_idle_released: assert property (bus_free |-> sda_out_b_oe_n)
      else $error("slave drove the data line on an idle bus");
   a_reset_release: assert property ($rose(rst_n_i) |-> sda_out_b_oe_n)
      else $error("slave not released when reset ends");
   a_clock_high_len: assert property ($fell(scl) |-> hi_cnt >= 8'(2 * QTR))
      else $error("clock high phase too short");

   c_slave_ack: cover property (scl && !$past(scl) && !sda_out_b_oe_n);
   c_stop: cover property (stop_w);
   c_restart: cover property (start_w && !bus_free);
endmodule : ssa_chk

// ===== test/testbench.sv
// Purpose: Self-checking bench joining the bus master to the serial slave
// Assumes: 50 MHz clock, link clock made by the master at 160 ns
// Notes:   Expected results are queued by the driver and popped by a monitor
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; $display("Error %s exp %h got %h", nm, e, g); end end
module testbench;
   localparam int QTR = 2;
   logic        clk_i, rst_n_i, cmd_valid_i, cmd_start_i, cmd_stop_i, cmd_read_i, cmd_ack_i;
   logic        cmd_ready_o, rsp_valid_o, rsp_ack_o, power_up_i, int_active_i, reg_wr_o, reg_rd_o;
   logic [7:0]  cmd_wdata_i, rsp_rdata_o, reg_rdata_i, reg_addr_o, reg_wdata_o, own, d, ptr;
   logic [3:0]  addr_sel_i, latched_address_register_o, sel;
   logic [9:0]  rsp_q[$];
   logic [9:0]  re;
   logic [15:0] wr_q[$];
   logic [15:0] we;
   logic [7:0]  rd_q[$];
   logic [7:0]  ra;
   int          err_total = 0;
   int          compares = 0;
   int          cyc = 0;

   ssa_link_if link ();
   ssa_host #(.QTR(QTR)) ssa_host_i (.clk_i, .rst_n_i, .link(link), .cmd_valid_i, .cmd_ready_o, .cmd_start_i,
      .cmd_stop_i, .cmd_read_i, .cmd_ack_i, .cmd_wdata_i, .rsp_valid_o, .rsp_rdata_o, .rsp_ack_o);
   ssa_slave ssa_slave_i (.clk_i, .rst_n_i, .link(link), .addr_sel_i, .power_up_i, .int_active_i, .reg_rdata_i,
      .reg_addr_o, .reg_wdata_o, .reg_wr_o, .reg_rd_o, .latched_address_register_o);
   ssa_chk #(.QTR(QTR)) ssa_chk_i (.clk_i, .rst_n_i, .scl(link.scl), .sda_out_b(link.sda_out_b),
      .sda_out_b_oe_n(link.sda_out_b_oe_n), .host_sda_o(link.host_sda_o), .host_sda_oe_n(link.host_sda_oe_n),
      .sda_in_a(link.sda_in_a));

   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task close_out;
      $display("Counts: compares=%0d errors=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out

   // One byte on the bus; the expected response is queued first
   task automatic op(input logic st, sp, rd, ak, input logic [7:0] wd, input logic eack, chk, input logic [7:0] ed);
      int n;
      @(posedge clk_i);
      cmd_valid_i <= 1'b1;
      cmd_start_i <= st;
      cmd_stop_i  <= sp;
      cmd_read_i  <= rd;
      cmd_ack_i   <= ak;
      cmd_wdata_i <= wd;
      rsp_q.push_back({eack, chk, ed});
      n = 0;
      @(negedge clk_i);
      while (cmd_ready_o !== 1'b1 && n < 4000)
      begin
         @(negedge clk_i);
         n++;
      end
      @(posedge clk_i);
      cmd_valid_i <= 1'b0;
   endtask : op

   task automatic drain;
      int n;
      n = 0;
      while ((rsp_q.size() != 0 || cmd_ready_o !== 1'b1) && n < 4000)
      begin
         @(negedge clk_i);
         n++;
      end
      repeat (20) @(posedge clk_i);
   endtask : drain

   // Register file stand-in: read data is a fixed function of the address
   always @(posedge clk_i)
      reg_rdata_i <= reg_addr_o ^ 8'ha5;

   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_total++;
         close_out();
      end
   end

   always @(posedge clk_i)
   begin
      if (rsp_valid_o === 1'b1)
      begin
         `CHK("rsp_expected", 1'b1, 1'(rsp_q.size() > 0))
         if (rsp_q.size() > 0)
         begin
            re = rsp_q.pop_front();
            `CHK("ack", re[9], rsp_ack_o)
            if (re[8]) `CHK("rdata", re[7:0], rsp_rdata_o)
         end
      end
      if (reg_wr_o === 1'b1)
      begin
         `CHK("wr_expected", 1'b1, 1'(wr_q.size() > 0))
         if (wr_q.size() > 0)
         begin
            we = wr_q.pop_front();
            `CHK("wr_addr_data", we, {reg_addr_o, reg_wdata_o})
         end
      end
      if (reg_rd_o === 1'b1)
      begin
         `CHK("rd_expected", 1'b1, 1'(rd_q.size() > 0))
         if (rd_q.size() > 0)
         begin
            ra = rd_q.pop_front();
            `CHK("rd_addr", ra, reg_addr_o)
         end
      end
   end

   initial
   begin
      void'($urandom(32'h54c6));
      {cmd_valid_i, cmd_start_i, cmd_stop_i, cmd_read_i, cmd_ack_i, power_up_i, int_active_i} = 7'h00;
      cmd_wdata_i = 8'h00;
      reg_rdata_i = 8'h00;
      sel = 4'($urandom);
      addr_sel_i = sel;
      rst_n_i = 1'b0;
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      `CHK("latched", sel, latched_address_register_o)
      own = {ssa_pkg::ADDR_FIXED, sel, 1'b0};
      // Burst write running into the last pointer
      op(1, 0, 0, 0, own, 1, 0, 8'h00);
      op(0, 0, 0, 0, 8'h25, 1, 0, 8'h00);
      ptr = 8'h25;
      for (int i = 0; i < 3; i++)
      begin
         d = 8'($urandom);
         wr_q.push_back({ptr, d});
         op(0, i == 2, 0, 0, d, 1, 0, 8'h00);
         if (ptr != ssa_pkg::PTR_LAST) ptr = ptr + ssa_pkg::PTR_STEP;
      end
      // Pointer-only write, then two reads
      op(1, 0, 0, 0, own, 1, 0, 8'h00);
      op(0, 1, 0, 0, 8'h10, 1, 0, 8'h00);
      rd_q = {8'h10, 8'h11};
      op(1, 0, 0, 0, own | 8'h01, 1, 0, 8'h00);
      op(0, 0, 1, 1, 8'h00, 1, 1, 8'h10 ^ 8'ha5);
      op(0, 1, 1, 0, 8'h00, 0, 1, 8'h11 ^ 8'ha5);
      // Repeated start between pointer and read
      op(1, 0, 0, 0, own, 1, 0, 8'h00);
      op(0, 0, 0, 0, 8'h20, 1, 0, 8'h00);
      rd_q.push_back(8'h20);
      op(1, 0, 0, 0, own | 8'h01, 1, 0, 8'h00);
      op(0, 1, 1, 0, 8'h00, 0, 1, 8'h20 ^ 8'ha5);
      // Foreign addresses
      op(1, 1, 0, 0, own ^ 8'h02, 0, 0, 8'h00);
      op(1, 1, 0, 0, own ^ 8'h80, 0, 0, 8'h00);
      // Global write
      op(1, 0, 0, 0, ssa_pkg::GLOBAL_WR, 1, 0, 8'h00);
      op(0, 0, 0, 0, 8'h05, 1, 0, 8'h00);
      d = 8'($urandom);
      wr_q.push_back({8'h05, d});
      op(0, 1, 0, 0, d, 1, 0, 8'h00);
      // Alert response without, then with, a pending interrupt
      op(1, 1, 0, 0, ssa_pkg::GLOBAL_RD, 0, 0, 8'h00);
      drain();
      int_active_i <= 1'b1;
      op(1, 0, 0, 0, ssa_pkg::GLOBAL_RD, 1, 0, 8'h00);
      op(0, 1, 1, 0, 8'h00, 0, 1, own | 8'h01);
      // Master drives a lower address into the answer: the slave must back off
      op(1, 0, 0, 0, ssa_pkg::GLOBAL_RD, 1, 0, 8'h00);
      op(0, 1, 0, 0, 8'h01, 0, 1, 8'h01);
      drain();
      // Selector recapture on power-up
      addr_sel_i <= ~sel;
      repeat (4) @(posedge clk_i);
      `CHK("held", sel, latched_address_register_o)
      power_up_i <= 1'b1;
      @(posedge clk_i);
      power_up_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      `CHK("recaptured", ~sel, latched_address_register_o)
      op(1, 1, 0, 0, own, 0, 0, 8'h00);
      op(1, 1, 0, 0, own ^ 8'h1e, 1, 0, 8'h00);
      drain();
      `CHK("writes_left", 8'h00, 8'(wr_q.size()))
      `CHK("reads_left", 8'h00, 8'(rd_q.size()))
      close_out();
   end
endmodule : testbench
